/* hw/uiel_top.sv */
// interrupt mask, line status and interrupt source logic of one uart channel
`timescale 1ns/1ns
module uiel_top (
   // clock and reset
   input wire logic clk,
   input wire logic rstn,
   // parallel register port
   input wire uiel_pkg::uiel_bus_type bus,
   output logic [7:0] rdata,
   // datapath status, same clock
   input wire uiel_pkg::uiel_dp_type dp,
   input wire logic holdWrite,
   input wire logic holdRead,
   input wire logic modemRead,
   // clear-to-send pin, asynchronous
   input wire logic ctsPin,
   // interrupt and configuration out
   output logic irq,
   output logic sleepEn,
   output logic polledMode,
   output uiel_pkg::uiel_cfg_type cfg
);

   typedef struct packed {
      uiel_pkg::uiel_cfg_type cfg;
      logic dataReady;
      logic overrun;
      logic [2:0] headErr;
      logic txPend;
      logic pausePend;
      logic flowPend;
      logic txCondPrev;
      logic rtsPrev;
      logic ctsPrev;
      logic [7:0] rdata;
      logic irq;
      logic polled;
      logic sleep;
   } uiel_state_type;

   uiel_state_type st_r;
   uiel_state_type st_nxt;

   logic ctsSync;
   logic enhKey;
   logic enh;
   logic [7:0] effMask;
   logic [5:0] rxTrig;
   logic [5:0] txTrig;
   logic rxReady;
   logic txCond;
   logic lineInt;
   logic toInt;
   logic rxInt;
   logic txInt;
   logic modemInt;
   logic pauseInt;
   logic flowInt;
   logic [5:0] srcCode;
   logic [7:0] lineStat;
   logic wrEn;
   logic rdEn;
   logic lineRead;
   logic srcRead;

   uiel_sync #(
      .WIDTH(1)
   ) ctsSyncInst (
      .clk(clk),
      .rstn(rstn),
      .din(ctsPin),
      .dout(ctsSync)
   );

   // decode helpers
   always_comb
   begin
      enhKey = (st_r.cfg.lineCtl == uiel_pkg::LCTL_ENH_KEY);
      enh = st_r.cfg.featureCtl[uiel_pkg::EFC_ENH_BIT];
      effMask = enh ? st_r.cfg.mask : {4'h0, st_r.cfg.mask[3:0]};
      wrEn = bus.cs && bus.wr;
      rdEn = bus.cs && bus.rd;
      lineRead = rdEn && !enhKey && (bus.addr == uiel_pkg::ADDR_LSTAT);
      srcRead = rdEn && !enhKey && (bus.addr == uiel_pkg::ADDR_SRC);
   end

   // trigger level lookup
   always_comb
   begin
      unique case (st_r.cfg.rxTrigSel)
         2'h0: rxTrig = uiel_pkg::RX_TRIG0;
         2'h1: rxTrig = uiel_pkg::RX_TRIG1;
         2'h2: rxTrig = uiel_pkg::RX_TRIG2;
         2'h3: rxTrig = uiel_pkg::RX_TRIG3;
      endcase
      // tx select is held at zero outside enhanced mode
      unique case (enh ? st_r.cfg.txTrigSel : 2'h0)
         2'h0: txTrig = uiel_pkg::TX_TRIG0;
         2'h1: txTrig = uiel_pkg::TX_TRIG1;
         2'h2: txTrig = uiel_pkg::TX_TRIG2;
         2'h3: txTrig = uiel_pkg::TX_TRIG3;
      endcase
   end

   // interrupt qualification
   always_comb
   begin
      lineStat[0] = st_r.dataReady;
      lineStat[1] = st_r.overrun;
      lineStat[4:2] = st_r.headErr;
      lineStat[5] = dp.holdEmpty;
      lineStat[6] = dp.holdEmpty && dp.shiftEmpty;
      lineStat[7] = st_r.cfg.fifoEn && dp.rxAnyErr;
      if (st_r.cfg.fifoEn)
      begin
         rxReady = (dp.rxLevel >= rxTrig);
         txCond = (dp.txLevel < txTrig);
      end
      else
      begin
         rxReady = st_r.dataReady;
         txCond = dp.holdEmpty;
      end
      // masked conditions other than flow pin rises keep their flags but stay off the output
      lineInt = effMask[2] && (|lineStat[4:1]);
      toInt = effMask[0] && st_r.cfg.fifoEn && dp.rxTimeout;
      rxInt = effMask[0] && rxReady;
      txInt = effMask[1] && st_r.txPend;
      modemInt = effMask[3] && dp.modemDelta;
      pauseInt = effMask[5] && st_r.pausePend;
      // a pending rise stays queued but only shows while one of its enables is live
      flowInt = (effMask[6] || effMask[7]) && st_r.flowPend;
   end

   // priority encoder: only the top pending source is shown
   always_comb
   begin
      if (lineInt)
      begin
         srcCode = uiel_pkg::SRC_LINE;
      end
      else if (toInt)
      begin
         srcCode = uiel_pkg::SRC_TIMEOUT;
      end
      else if (rxInt)
      begin
         srcCode = uiel_pkg::SRC_RXRDY;
      end
      else if (txInt)
      begin
         srcCode = uiel_pkg::SRC_TXRDY;
      end
      else if (modemInt)
      begin
         srcCode = uiel_pkg::SRC_MODEM;
      end
      else if (pauseInt)
      begin
         srcCode = uiel_pkg::SRC_PAUSE;
      end
      else if (flowInt)
      begin
         srcCode = uiel_pkg::SRC_FLOW;
      end
      else
      begin
         srcCode = uiel_pkg::SRC_NONE;
      end
   end

   // next state
   always_comb
   begin
      st_nxt = st_r;

      // register writes
      if (wrEn)
      begin
         if (enhKey)
         begin
            unique case (bus.addr)
               uiel_pkg::ADDR_EFC: st_nxt.cfg.featureCtl = bus.wdata;
               uiel_pkg::ADDR_RESUME1: st_nxt.cfg.resume1 = bus.wdata;
               uiel_pkg::ADDR_RESUME2: st_nxt.cfg.resume2 = bus.wdata;
               uiel_pkg::ADDR_PAUSE1: st_nxt.cfg.pause1 = bus.wdata;
               uiel_pkg::ADDR_PAUSE2: st_nxt.cfg.pause2 = bus.wdata;
               uiel_pkg::ADDR_LCTL: st_nxt.cfg.lineCtl = bus.wdata;
               default: st_nxt.cfg = st_r.cfg;
            endcase
         end
         else if (bus.addr == uiel_pkg::ADDR_LCTL)
         begin
            st_nxt.cfg.lineCtl = bus.wdata;
         end
         else if (bus.addr == uiel_pkg::ADDR_MASK && !st_r.cfg.lineCtl[uiel_pkg::LCTL_DIVEN_BIT])
         begin
            st_nxt.cfg.mask[3:0] = bus.wdata[3:0];
            if (enh)
            begin
               st_nxt.cfg.mask[7:4] = bus.wdata[7:4];
            end
         end
         else if (bus.addr == uiel_pkg::ADDR_SRC && !st_r.cfg.lineCtl[uiel_pkg::LCTL_DIVEN_BIT])
         begin
            // other fifo control bits only take with the enable set
            st_nxt.cfg.fifoEn = bus.wdata[0];
            if (bus.wdata[0])
            begin
               st_nxt.cfg.rxTrigSel = bus.wdata[7:6];
               if (enh)
               begin
                  st_nxt.cfg.txTrigSel = bus.wdata[5:4];
               end
            end
         end
      end

      // data ready: set on load wins over empty
      if (dp.rxLoad)
      begin
         st_nxt.dataReady = 1'b1;
      end
      else if (dp.rxEmpty)
      begin
         st_nxt.dataReady = 1'b0;
      end

      // overrun flags at once; head errors latch as the character reaches the read position
      if (lineRead)
      begin
         st_nxt.overrun = 1'b0;
         st_nxt.headErr = 3'h0;
      end
      if (dp.rxOverrun)
      begin
         st_nxt.overrun = 1'b1;
      end
      if (holdRead || dp.rxLoad)
      begin
         st_nxt.headErr = st_nxt.headErr | dp.rxHeadErr;
      end

      // tx ready pending: new empty edge (fifo on: drop below tx trigger), or mask set while already so
      st_nxt.txCondPrev = txCond;
      if (holdWrite || (srcRead && srcCode == uiel_pkg::SRC_TXRDY))
      begin
         st_nxt.txPend = 1'b0;
      end
      if (txCond && !st_r.txCondPrev)
      begin
         st_nxt.txPend = 1'b1;
      end
      if (st_nxt.cfg.mask[1] && !st_r.cfg.mask[1] && txCond)
      begin
         st_nxt.txPend = 1'b1;
      end

      // pause character pending
      if (dp.resumeSeen || (srcRead && srcCode == uiel_pkg::SRC_PAUSE))
      begin
         st_nxt.pausePend = 1'b0;
      end
      if (dp.pauseSeen)
      begin
         st_nxt.pausePend = 1'b1;
      end

      // flow pin rise pending, cleared by a modem status read
      st_nxt.rtsPrev = dp.rtsOut;
      st_nxt.ctsPrev = ctsSync;
      if (modemRead)
      begin
         st_nxt.flowPend = 1'b0;
      end
      if (effMask[6] && dp.rtsOut && !st_r.rtsPrev)
      begin
         st_nxt.flowPend = 1'b1;
      end
      if (effMask[7] && ctsSync && !st_r.ctsPrev)
      begin
         st_nxt.flowPend = 1'b1;
      end

      // read data
      st_nxt.rdata = 8'h00;
      if (rdEn)
      begin
         if (enhKey)
         begin
            unique case (bus.addr)
               uiel_pkg::ADDR_EFC: st_nxt.rdata = st_r.cfg.featureCtl;
               uiel_pkg::ADDR_RESUME1: st_nxt.rdata = st_r.cfg.resume1;
               uiel_pkg::ADDR_RESUME2: st_nxt.rdata = st_r.cfg.resume2;
               uiel_pkg::ADDR_PAUSE1: st_nxt.rdata = st_r.cfg.pause1;
               uiel_pkg::ADDR_PAUSE2: st_nxt.rdata = st_r.cfg.pause2;
               uiel_pkg::ADDR_LCTL: st_nxt.rdata = st_r.cfg.lineCtl;
               default: st_nxt.rdata = 8'h00;
            endcase
         end
         else
         begin
            unique case (bus.addr)
               uiel_pkg::ADDR_MASK: st_nxt.rdata = effMask;
               uiel_pkg::ADDR_SRC: st_nxt.rdata = {{2{st_r.cfg.fifoEn}}, srcCode};
               uiel_pkg::ADDR_LCTL: st_nxt.rdata = st_r.cfg.lineCtl;
               uiel_pkg::ADDR_LSTAT: st_nxt.rdata = lineStat;
               default: st_nxt.rdata = 8'h00;
            endcase
         end
      end

      // no enabled source means the line stays quiet
      st_nxt.irq = (srcCode != uiel_pkg::SRC_NONE);
      st_nxt.polled = st_r.cfg.fifoEn && (st_r.cfg.mask[3:0] == 4'h0);
      st_nxt.sleep = st_nxt.cfg.mask[4] && st_nxt.cfg.featureCtl[uiel_pkg::EFC_ENH_BIT];
   end

   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         st_r <= '0;
         st_r.cfg.mask <= uiel_pkg::RST_MASK;
         st_r.cfg.featureCtl <= uiel_pkg::RST_EFC;
         st_r.cfg.lineCtl <= uiel_pkg::RST_LCTL;
         st_r.cfg.resume1 <= uiel_pkg::RST_CHAR;
         st_r.cfg.resume2 <= uiel_pkg::RST_CHAR;
         st_r.cfg.pause1 <= uiel_pkg::RST_CHAR;
         st_r.cfg.pause2 <= uiel_pkg::RST_CHAR;
      end
      else
      begin
         st_r <= st_nxt;
      end
   end

   assign rdata = st_r.rdata;
   assign irq = st_r.irq;
   assign sleepEn = st_r.sleep;
   assign polledMode = st_r.polled;
   assign cfg = st_r.cfg;

endmodule

/* include/uiel_pkg.sv */
// package for the uart interrupt enable logic: register map, fields, types
//
// Function
// - enhanced-only bits inert unless feature bit 4
// - rx data interrupt follows fifo trigger level
// - source write bits 6-7 set rx trigger level
// - data ready set on load, cleared when empty
// - fifo on, mask 0-3 clear: polled mode
// - overrun sets line status bit 1
// - bits 2-4 give head character error kinds
// - bit 5 holding empty, bit 6 all empty
// - bit 7 flags any errored character in fifo
// - mask bit 0 gates receive data interrupt
// - mask bit 1 gates transmit ready interrupt
// - enabling tx mask while empty interrupts at once
// - mask bit 2 gates line status interrupt
// - overrun immediate, other errors on readout
// - mask bit 3 gates modem status interrupt
// - mask bit 4 sleep, enhanced writes only
// - mask bit 5 gates pause character interrupt
// - mask bit 6 gates request-to-send rise
// - highest enabled interrupt shows in source register
// - mask bit 7 gates clear-to-send rise
// - source read gives highest pending, rest wait
package uiel_pkg;

   // register addresses on the three address lines
   localparam logic [2:0] ADDR_HOLD = 3'h0;
   localparam logic [2:0] ADDR_MASK = 3'h1;
   localparam logic [2:0] ADDR_SRC = 3'h2;
   localparam logic [2:0] ADDR_LCTL = 3'h3;
   localparam logic [2:0] ADDR_LSTAT = 3'h5;
   localparam logic [2:0] ADDR_MSTAT = 3'h6;
   localparam logic [2:0] ADDR_EFC = 3'h2;
   localparam logic [2:0] ADDR_RESUME1 = 3'h4;
   localparam logic [2:0] ADDR_RESUME2 = 3'h5;
   localparam logic [2:0] ADDR_PAUSE1 = 3'h6;
   localparam logic [2:0] ADDR_PAUSE2 = 3'h7;

   // line control value that opens the enhanced group
   localparam logic [7:0] LCTL_ENH_KEY = 8'hbf;
   localparam int LCTL_DIVEN_BIT = 7;
   localparam int EFC_ENH_BIT = 4;

   // reset values
   localparam logic [7:0] RST_MASK = 8'h00;
   localparam logic [7:0] RST_EFC = 8'h00;
   localparam logic [7:0] RST_LCTL = 8'h00;
   localparam logic [7:0] RST_CHAR = 8'h00;

   // interrupt source codes, bits 5:0
   localparam logic [5:0] SRC_LINE = 6'h06;
   localparam logic [5:0] SRC_TIMEOUT = 6'h0c;
   localparam logic [5:0] SRC_RXRDY = 6'h04;
   localparam logic [5:0] SRC_TXRDY = 6'h02;
   localparam logic [5:0] SRC_MODEM = 6'h00;
   localparam logic [5:0] SRC_PAUSE = 6'h10;
   localparam logic [5:0] SRC_FLOW = 6'h20;
   localparam logic [5:0] SRC_NONE = 6'h01;

   // fifo trigger levels, indexed by the two select bits
   localparam logic [5:0] RX_TRIG0 = 6'd8;
   localparam logic [5:0] RX_TRIG1 = 6'd16;
   localparam logic [5:0] RX_TRIG2 = 6'd24;
   localparam logic [5:0] RX_TRIG3 = 6'd28;
   localparam logic [5:0] TX_TRIG0 = 6'd16;
   localparam logic [5:0] TX_TRIG1 = 6'd8;
   localparam logic [5:0] TX_TRIG2 = 6'd24;
   localparam logic [5:0] TX_TRIG3 = 6'd30;

   typedef struct packed {
      logic cs;
      logic wr;
      logic rd;
      logic [2:0] addr;
      logic [7:0] wdata;
   } uiel_bus_type;

   // receiver, transmitter and modem status from the datapath
   typedef struct packed {
      logic [5:0] rxLevel;
      logic rxLoad;
      logic rxEmpty;
      logic rxOverrun;
      logic [2:0] rxHeadErr;
      logic rxAnyErr;
      logic rxTimeout;
      logic [5:0] txLevel;
      logic holdEmpty;
      logic shiftEmpty;
      logic modemDelta;
      logic pauseSeen;
      logic resumeSeen;
      logic rtsOut;
   } uiel_dp_type;

   typedef struct packed {
      logic [7:0] lineCtl;
      logic [7:0] featureCtl;
      logic [7:0] mask;
      logic fifoEn;
      logic [1:0] rxTrigSel;
      logic [1:0] txTrigSel;
      logic [7:0] resume1;
      logic [7:0] resume2;
      logic [7:0] pause1;
      logic [7:0] pause2;
   } uiel_cfg_type;

endpackage

/* hw/uiel_sync.sv */
// two flip-flop synchroniser for pin levels
`timescale 1ns/1ns
module uiel_sync #(
   parameter int WIDTH = 1
) (
   // clock and reset
   input wire logic clk,
   input wire logic rstn,
   // level in and out
   input wire logic [WIDTH-1:0] din,
   output logic [WIDTH-1:0] dout
);

   typedef struct packed {
      logic [WIDTH-1:0] meta;
      logic [WIDTH-1:0] sync;
   } uiel_sync_type;

   uiel_sync_type st_r;
   uiel_sync_type st_nxt;

   always_comb
   begin
      st_nxt.meta = din;
      st_nxt.sync = st_r.meta;
   end

   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         st_r <= '0;
      end
      else
      begin
         st_r <= st_nxt;
      end
   end

   assign dout = st_r.sync;

endmodule

/* test/uiel_top_chk.sv */
// port assertions for the interrupt mask, line status and source logic
`timescale 1ns/1ns
module uiel_top_chk (
   // clock and reset
   input wire logic clk,
   input wire logic rstn,
   // register port
   input wire uiel_pkg::uiel_bus_type bus,
   input wire logic [7:0] rdata,
   // datapath side
   input wire uiel_pkg::uiel_dp_type dp,
   input wire logic holdWrite,
   input wire logic holdRead,
   input wire logic modemRead,
   input wire logic ctsPin,
   // outputs
   input wire logic irq,
   input wire logic sleepEn,
   input wire logic polledMode,
   input wire uiel_pkg::uiel_cfg_type cfg
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rstn);
   logic [5:0] rxTrig;
   logic maskWr;
   logic lsRd;
   logic srcRd;
   logic pollCond;
   logic sleepCond;
   logic [2:0] lsExp;
   assign rxTrig = cfg.rxTrigSel[1] ? (cfg.rxTrigSel[0] ? uiel_pkg::RX_TRIG3 : uiel_pkg::RX_TRIG2)
      : (cfg.rxTrigSel[0] ? uiel_pkg::RX_TRIG1 : uiel_pkg::RX_TRIG0);
   assign maskWr = bus.cs && bus.wr && bus.addr == uiel_pkg::ADDR_MASK && !cfg.lineCtl[7];
   assign lsRd = bus.cs && bus.rd && bus.addr == uiel_pkg::ADDR_LSTAT && cfg.lineCtl != uiel_pkg::LCTL_ENH_KEY;
   assign srcRd = bus.cs && bus.rd && bus.addr == uiel_pkg::ADDR_SRC && cfg.lineCtl != uiel_pkg::LCTL_ENH_KEY;
   assign pollCond = cfg.fifoEn && cfg.mask[3:0] == 4'h0;
   assign sleepCond = cfg.mask[4] && cfg.featureCtl[4];
   assign lsExp = {cfg.fifoEn && dp.rxAnyErr, dp.holdEmpty && dp.shiftEmpty, dp.holdEmpty};

   chk_mask_reset:
   assert property (!$past(rstn) |-> cfg.mask == 8'h00) else $error("mask not clear after reset");
   chk_mask_write:
   assert property (maskWr |=> cfg.mask[3:0] == $past(bus.wdata[3:0])) else $error("mask write lost");
   chk_upper_lock:
   assert property (maskWr && !cfg.featureCtl[4] |=> $stable(cfg.mask[7:4])) else $error("upper mask writable");
   chk_poll_mode:
   assert property ($stable(pollCond) |-> polledMode == pollCond) else $error("polled mode wrong");
   chk_sleep_en:
   assert property ($stable(sleepCond) |-> sleepEn == sleepCond) else $error("sleep enable wrong");
   chk_irq_masked:
   assert property (cfg.mask == 8'h00 [*3] |-> !irq) else $error("irq with all masks clear");
   chk_rx_irq:
   assert property ((cfg.mask == 8'h01 && cfg.fifoEn && dp.rxLevel >= rxTrig) [*3] |-> irq)
      else $error("rx trigger irq missing");
   chk_rx_quiet:
   assert property ((cfg.mask == 8'h01 && cfg.fifoEn && dp.rxLevel < rxTrig && !dp.rxTimeout) [*3] |-> !irq)
      else $error("rx irq below trigger");
   chk_tx_at_once:
   assert property ($rose(cfg.mask[1]) && !cfg.fifoEn && dp.holdEmpty |-> ##[0:3] irq)
      else $error("tx irq missing on enable");
   chk_lstat_bits:
   assert property (lsRd && $stable(dp) |=> rdata[7:5] == $past(lsExp)) else $error("line status 7:5 wrong");
   chk_src_upper:
   assert property (srcRd && !cfg.featureCtl[4] |=> rdata[5:4] == 2'h0) else $error("upper source bits active");
endmodule
bind uiel_top uiel_top_chk chk (.clk(clk), .rstn(rstn), .bus(bus), .rdata(rdata), .dp(dp),
   .holdWrite(holdWrite), .holdRead(holdRead), .modemRead(modemRead), .ctsPin(ctsPin), .irq(irq),
   .sleepEn(sleepEn), .polledMode(polledMode), .cfg(cfg));

/* test/uiel_host.sv */
// host processor model on the parallel register port
`timescale 1ns/1ns
module uiel_host (
   // clock
   input wire logic clk,
   // register port
   output uiel_pkg::uiel_bus_type bus,
   input wire logic [7:0] rdata
);
   initial
   begin
      bus = '0;
   end
   // one access per call; idle address and data inverted so stale values never look valid
   task automatic acc(input logic w, input logic [2:0] a, input logic [7:0] d, output logic [7:0] q);
      @(negedge clk);
      bus = '{cs: 1'b1, wr: w, rd: !w, addr: a, wdata: d};
      @(negedge clk);
      q = rdata;
      bus = '{cs: 1'b0, wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
   endtask
endmodule

/* test/uiel_top_tb_top.sv */
// self-checking bench for the interrupt mask and line status logic
`timescale 1ns/1ns
module uiel_top_tb_top;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   uiel_pkg::uiel_bus_type bus;
   uiel_pkg::uiel_dp_type dp = '0;
   uiel_pkg::uiel_cfg_type cfg;
   logic [7:0] rdata;
   logic holdWrite = 1'b0;
   logic holdRead = 1'b0;
   logic modemRead = 1'b0;
   logic ctsPin = 1'b0;
   logic irq;
   logic sleepEn;
   logic polledMode;
   logic [7:0] q;
   logic [7:0] d;
   logic [5:0] lv;
   int seed = 67962;
   int fail_count = 0;
   int num_checks = 0;
   int cycles = 0;

   uiel_top dut (.clk(clk), .rstn(rstn), .bus(bus), .rdata(rdata), .dp(dp), .holdWrite(holdWrite),
      .holdRead(holdRead), .modemRead(modemRead), .ctsPin(ctsPin), .irq(irq), .sleepEn(sleepEn),
      .polledMode(polledMode), .cfg(cfg));
   uiel_host host (.clk(clk), .bus(bus), .rdata(rdata));

   always #4 clk = ~clk;

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   // generous ceiling, the sequence needs well under a thousand cycles
   always @(posedge clk)
   begin
      cycles <= cycles + 1;
      if (cycles == 5000)
      begin
         fail_count++;
         report_and_stop();
      end
   end

   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask

   function automatic logic [5:0] rxTrig(input logic [1:0] s);
      return s[1] ? (s[0] ? uiel_pkg::RX_TRIG3 : uiel_pkg::RX_TRIG2) : (s[0] ? uiel_pkg::RX_TRIG1 : uiel_pkg::RX_TRIG0);
   endfunction

   task automatic wr(input logic [2:0] a, input logic [7:0] v);
      host.acc(1'b1, a, v, q);
   endtask

   task automatic rd(input logic [2:0] a);
      host.acc(1'b0, a, 8'h00, q);
   endtask

   // cause to irq takes two cycles, three leave margin
   task automatic irqIs(input logic e);
      repeat (3) @(negedge clk);
      check("irq", 8'(irq), 8'(e));
   endtask

   initial
   begin
      dp.rxEmpty = 1'b1;
      dp.holdEmpty = 1'b1;
      dp.shiftEmpty = 1'b1;
      repeat (8) @(negedge clk);
      rstn = 1'b1;
      rd(uiel_pkg::ADDR_MASK);
      check("mask reset", q, uiel_pkg::RST_MASK);
      rd(uiel_pkg::ADDR_SRC);
      check("source idle", q, 8'h01);
      rd(3'h7);
      check("unmapped", q, 8'h00);
      wr(uiel_pkg::ADDR_LCTL, uiel_pkg::LCTL_ENH_KEY);
      rd(uiel_pkg::ADDR_EFC);
      check("feature reset", q, uiel_pkg::RST_EFC);
      for (int i = 2; i < 8; i++)
      begin
         if (i != 3)
         begin
            d = 8'($random(seed));
            wr(3'(i), d);
            rd(3'(i));
            check("enhanced reg", q, d);
         end
      end
      wr(uiel_pkg::ADDR_EFC, 8'h00);
      wr(uiel_pkg::ADDR_LCTL, 8'h03);
      wr(uiel_pkg::ADDR_MASK, 8'hf0);
      rd(uiel_pkg::ADDR_MASK);
      check("mask locked", q, 8'h00);
      check("sleep off", 8'(sleepEn), 8'h00);
      wr(uiel_pkg::ADDR_LCTL, uiel_pkg::LCTL_ENH_KEY);
      wr(uiel_pkg::ADDR_EFC, 8'h10);
      wr(uiel_pkg::ADDR_LCTL, 8'h03);
      wr(uiel_pkg::ADDR_MASK, 8'h10);
      rd(uiel_pkg::ADDR_MASK);
      check("mask upper", q, 8'h10);
      check("sleep on", 8'(sleepEn), 8'h01);
      wr(uiel_pkg::ADDR_MASK, 8'h00);
      wr(uiel_pkg::ADDR_SRC, 8'h01);
      repeat (2) @(negedge clk);
      check("polled", 8'(polledMode), 8'h01);
      wr(uiel_pkg::ADDR_MASK, 8'h01);
      repeat (2) @(negedge clk);
      check("not polled", 8'(polledMode), 8'h00);
      for (int i = 0; i < 4; i++)
      begin
         wr(uiel_pkg::ADDR_SRC, {2'(i), 6'h01});
         lv = rxTrig(2'(i));
         dp.rxEmpty = 1'b0;
         dp.rxLevel = lv - 6'd1;
         irqIs(1'b0);
         rd(uiel_pkg::ADDR_SRC);
         check("source below", q, 8'hc1);
         dp.rxLevel = lv + 6'(($random(seed)) & 3);
         irqIs(1'b1);
         rd(uiel_pkg::ADDR_SRC);
         check("source trigger", q, {2'b11, uiel_pkg::SRC_RXRDY});
         dp.rxLevel = lv - 6'd1;
         irqIs(1'b0);
      end
      dp.rxLevel = 6'd0;
      dp.rxEmpty = 1'b1;
      wr(uiel_pkg::ADDR_MASK, 8'h04);
      repeat (4)
      begin
         {dp.holdEmpty, dp.shiftEmpty, dp.rxAnyErr} = 3'($random(seed));
         rd(uiel_pkg::ADDR_LSTAT);
         check("line status", q, {dp.rxAnyErr, dp.holdEmpty && dp.shiftEmpty, dp.holdEmpty, 5'h00});
      end
      dp.rxAnyErr = 1'b0;
      dp.rxEmpty = 1'b0;
      dp.rxLoad = 1'b1;
      @(negedge clk);
      dp.rxLoad = 1'b0;
      rd(uiel_pkg::ADDR_LSTAT);
      check("data ready", 8'(q[0]), 8'h01);
      dp.rxEmpty = 1'b1;
      rd(uiel_pkg::ADDR_LSTAT);
      check("data gone", 8'(q[0]), 8'h00);
      dp.rxOverrun = 1'b1;
      @(negedge clk);
      dp.rxOverrun = 1'b0;
      irqIs(1'b1);
      rd(uiel_pkg::ADDR_SRC);
      check("source line", q, {2'b11, uiel_pkg::SRC_LINE});
      rd(uiel_pkg::ADDR_LSTAT);
      check("overrun", 8'(q[1]), 8'h01);
      irqIs(1'b0);
      dp.rxHeadErr = 3'($random(seed)) | 3'h1;
      irqIs(1'b0);
      holdRead = 1'b1;
      @(negedge clk);
      holdRead = 1'b0;
      irqIs(1'b1);
      rd(uiel_pkg::ADDR_LSTAT);
      check("head errors", 8'(q[4:2]), 8'(dp.rxHeadErr));
      dp.rxHeadErr = 3'h0;
      wr(uiel_pkg::ADDR_SRC, 8'h00);
      wr(uiel_pkg::ADDR_MASK, 8'h00);
      {dp.holdEmpty, dp.shiftEmpty} = 2'b11;
      wr(uiel_pkg::ADDR_MASK, 8'h02);
      irqIs(1'b1);
      rd(uiel_pkg::ADDR_SRC);
      check("source tx", q, {2'b00, uiel_pkg::SRC_TXRDY});
      irqIs(1'b0);
      dp.holdEmpty = 1'b0;
      irqIs(1'b0);
      dp.holdEmpty = 1'b1;
      irqIs(1'b1);
      dp.holdEmpty = 1'b0;
      holdWrite = 1'b1;
      @(negedge clk);
      holdWrite = 1'b0;
      irqIs(1'b0);
      wr(uiel_pkg::ADDR_MASK, 8'h00);
      dp.rxOverrun = 1'b1;
      @(negedge clk);
      dp.rxOverrun = 1'b0;
      irqIs(1'b0);
      rd(uiel_pkg::ADDR_LSTAT);
      check("masked overrun", 8'(q[1]), 8'h01);
      dp.modemDelta = 1'b1;
      wr(uiel_pkg::ADDR_MASK, 8'h08);
      irqIs(1'b1);
      rd(uiel_pkg::ADDR_SRC);
      check("source modem", q, {2'b00, uiel_pkg::SRC_MODEM});
      dp.modemDelta = 1'b0;
      irqIs(1'b0);
      wr(uiel_pkg::ADDR_MASK, 8'h20);
      dp.pauseSeen = 1'b1;
      @(negedge clk);
      dp.pauseSeen = 1'b0;
      irqIs(1'b1);
      rd(uiel_pkg::ADDR_SRC);
      check("source pause", q, {2'b00, uiel_pkg::SRC_PAUSE});
      irqIs(1'b0);
      wr(uiel_pkg::ADDR_MASK, 8'hc0);
      dp.rtsOut = 1'b1;
      irqIs(1'b1);
      rd(uiel_pkg::ADDR_SRC);
      check("source flow", q, {2'b00, uiel_pkg::SRC_FLOW});
      modemRead = 1'b1;
      @(negedge clk);
      modemRead = 1'b0;
      irqIs(1'b0);
      // pin passes two sync stages before the edge is seen
      ctsPin = 1'b1;
      repeat (2) @(negedge clk);
      irqIs(1'b1);
      modemRead = 1'b1;
      @(negedge clk);
      modemRead = 1'b0;
      irqIs(1'b0);
      wr(uiel_pkg::ADDR_MASK, 8'h1c);
      dp.modemDelta = 1'b1;
      dp.rxOverrun = 1'b1;
      @(negedge clk);
      dp.rxOverrun = 1'b0;
      rd(uiel_pkg::ADDR_SRC);
      check("source first", q, {2'b00, uiel_pkg::SRC_LINE});
      rd(uiel_pkg::ADDR_LSTAT);
      rd(uiel_pkg::ADDR_SRC);
      check("source next", q, {2'b00, uiel_pkg::SRC_MODEM});
      check("sleep before reset", 8'(sleepEn), 8'h01);
      dp.modemDelta = 1'b0;
      rstn = 1'b0;
      repeat (2) @(negedge clk);
      rstn = 1'b1;
      rd(uiel_pkg::ADDR_MASK);
      check("mask after reset", q, uiel_pkg::RST_MASK);
      check("sleep after reset", 8'(sleepEn), 8'h00);
      irqIs(1'b0);
      report_and_stop();
   end
endmodule
